// ==== rtl/lpddr_cmd_pkg.sv ====
// shared constants and types for the sdram command decoder and bank tracker
package lpddr_cmd_pkg;

  // geometry
  localparam int NUM_BANKS  = 4;
  localparam int BANK_W     = 2;
  localparam int ADDR_W     = 13;
  localparam int COL_W      = 9;
  localparam int AP_BIT     = 10;   // auto precharge / all-banks address bit
  localparam int MASK_W     = 2;

  // clock
  localparam int CLK_PERIOD_PS = 40000;

  // timings in picoseconds
  localparam int PRECHARGE_TIME_PS   = 15000;
  localparam int ACT_TO_ACCESS_PS    = 15000;
  localparam int REFRESH_CYCLE_PS    = 72000;
  localparam int MODE_LOAD_WAIT_PS   = 10000;

  // least times round up, never below one cycle
  function automatic int min_cycles(input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int PRECHARGE_CYC = min_cycles(PRECHARGE_TIME_PS);
  localparam int ACT_CYC       = min_cycles(ACT_TO_ACCESS_PS);
  localparam int REFRESH_CYC   = min_cycles(REFRESH_CYCLE_PS);
  localparam int MODE_CYC      = min_cycles(MODE_LOAD_WAIT_PS);

  // burst length in beats (two beats per clock)
  localparam int BURST_LEN     = 4;
  localparam int BURST_CYC     = BURST_LEN / 2;
  localparam int TMR_W         = 8;

  // decoded command {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] ENC_IDLE   = 4'h7;
  localparam logic [3:0] ENC_ACT    = 4'h3;
  localparam logic [3:0] ENC_READ   = 4'h5;
  localparam logic [3:0] ENC_WRITE  = 4'h4;
  localparam logic [3:0] ENC_TERM   = 4'h6;
  localparam logic [3:0] ENC_PRE    = 4'h2;
  localparam logic [3:0] ENC_REF    = 4'h1;
  localparam logic [3:0] ENC_MODE   = 4'h0;

  typedef enum logic [3:0] {
    CMD_DESEL, CMD_IDLE, CMD_ACT, CMD_READ, CMD_WRITE, CMD_TERM,
    CMD_PRE, CMD_REF, CMD_MODE, CMD_SELF_REF, CMD_SLEEP, CMD_BAD
  } cmd_t;

  typedef enum logic [2:0] {
    BANK_IDLE, BANK_ACTIVATING, BANK_ACTIVE, BANK_READ, BANK_WRITE, BANK_PRECHARGING
  } bank_state_t;

  typedef enum logic [1:0] {
    DEV_NORMAL, DEV_SELF_REFRESH, DEV_DEEP_SLEEP
  } dev_state_t;

  // mode register targets by {bank_select_hi, bank_select}
  localparam logic [1:0] MR_STD    = 2'h0;
  localparam logic [1:0] MR_STATUS = 2'h1;
  localparam logic [1:0] MR_EXT    = 2'h2;

endpackage

// ==== rtl/bank_tracker.sv ====
// per-bank state machine with timed transitions
`timescale 1ns/1ps
`default_nettype none
module bank_tracker
(
  // clock and reset
  input  wire logic                                clock,
  input  wire logic                                nrst,
  // decoded request for this bank
  input  wire logic                                do_act,
  input  wire logic                                do_read,
  input  wire logic                                do_write,
  input  wire logic                                do_pre,
  input  wire logic                                do_term,
  input  wire logic                                auto_pre,
  input  wire logic [lpddr_cmd_pkg::ADDR_W-1:0]    row,
  input  wire logic                                wipe,
  // state
  output lpddr_cmd_pkg::bank_state_t               state,
  output logic                                     ap_pending,
  output logic [lpddr_cmd_pkg::ADDR_W-1:0]         open_row
);
  localparam int TW = lpddr_cmd_pkg::TMR_W;
  localparam logic [TW-1:0] T_PRE = TW'(lpddr_cmd_pkg::PRECHARGE_CYC);
  localparam logic [TW-1:0] T_ACT = TW'(lpddr_cmd_pkg::ACT_CYC);
  localparam logic [TW-1:0] T_BST = TW'(lpddr_cmd_pkg::BURST_CYC);

  lpddr_cmd_pkg::bank_state_t state_q;
  logic [TW-1:0]              tmr_q;
  logic                       ap_q;
  logic [lpddr_cmd_pkg::ADDR_W-1:0] row_q;

  assign state      = state_q;
  assign ap_pending = ap_q;
  assign open_row   = row_q;

  // state walk; a precharge wins over any burst in flight
  always_ff @(posedge clock)
  begin
    if (!nrst || wipe)
    begin
      state_q <= lpddr_cmd_pkg::BANK_IDLE;
      tmr_q   <= '0;
      ap_q    <= 1'b0;
    end
    else if (do_pre)
    begin
      state_q <= lpddr_cmd_pkg::BANK_PRECHARGING;  // [RULE10] [RULE19] [RULE20]
      tmr_q   <= T_PRE;
      ap_q    <= 1'b0;
    end
    else if (do_act)
    begin
      state_q <= lpddr_cmd_pkg::BANK_ACTIVATING;   // [RULE3]
      tmr_q   <= T_ACT;
    end
    else if (do_read || do_write)
    begin
      state_q <= do_read ? lpddr_cmd_pkg::BANK_READ : lpddr_cmd_pkg::BANK_WRITE;
      tmr_q   <= T_BST;
      ap_q    <= auto_pre;                          // [RULE5] [RULE7]
    end
    else if (do_term)
    begin
      state_q <= lpddr_cmd_pkg::BANK_ACTIVE;       // row stays open [RULE12]
      tmr_q   <= '0;
    end
    else if (tmr_q > 1)
      tmr_q <= tmr_q - 1'b1;                        // idle and deselect do not disturb [RULE1]
    else
    begin
      tmr_q <= '0;
      case (state_q)
        lpddr_cmd_pkg::BANK_ACTIVATING:  state_q <= lpddr_cmd_pkg::BANK_ACTIVE;
        lpddr_cmd_pkg::BANK_PRECHARGING: state_q <= lpddr_cmd_pkg::BANK_IDLE;   // [RULE11]
        lpddr_cmd_pkg::BANK_READ, lpddr_cmd_pkg::BANK_WRITE:
        begin
          if (ap_q)
          begin
            state_q <= lpddr_cmd_pkg::BANK_PRECHARGING;  // [RULE6] [RULE7]
            tmr_q   <= T_PRE;
            ap_q    <= 1'b0;
          end
          else
            state_q <= lpddr_cmd_pkg::BANK_ACTIVE;
        end
        default: state_q <= state_q;
      endcase
    end
  end

  // open row latch
  always_ff @(posedge clock)
  begin
    if (!nrst)
      row_q <= '0;
    else if (do_act)
      row_q <= row;                                 // [RULE3]
  end
endmodule
`default_nettype wire

// ==== rtl/lpddr_command_bank_state.sv ====
// command decoder, device mode tracking and bank array of the sdram
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// How it works
// RULE1 - idle command starts nothing
// RULE2 - mode load with all banks idle, then wait
// RULE3 - activate opens a row until precharge
// RULE4 - precharge before another row
// RULE5 - read takes bank, column, auto precharge
// RULE6 - auto precharge read closes row at end
// RULE7 - write likewise, auto precharge at end
// RULE8 - byte stored only with mask low
// RULE9 - clock runs until bursts end
// RULE10 - bit ten high precharges all banks
// RULE11 - precharged bank idles after precharge time
// RULE12 - terminate cuts latest plain read
// RULE13 - auto refresh uses internal row counter
// RULE14 - refresh with clock gate low enters self refresh
// RULE15 - refresh bursts around self refresh
// RULE16 - terminate with clock gate low enters deep sleep
// RULE17 - deselect and idle continue previous work
// RULE18 - idle: activate, refresh, mode; active: read, write, precharge
// RULE19 - reading: read, write, precharge, terminate
// RULE20 - writing: read, write, precharge
// RULE21 - commands need clock gate high two edges
// RULE22 - busy banks get only idle commands; the code still accepts a precharge to a precharging bank
// RULE23 - bank select picks mode register
// RULE24 - deselect executes nothing new
// RULE25 - end a read before a write
// RULE26 - unsupported commands flag a violation
module lpddr_command_bank_state
#(
  parameter int NB = lpddr_cmd_pkg::NUM_BANKS,
  parameter int AW = lpddr_cmd_pkg::ADDR_W,
  parameter int MW = lpddr_cmd_pkg::MASK_W
)
(
  // clock and reset
  input  wire logic                              clock,
  input  wire logic                              nrst,
  // command pins
  input  wire logic                              clock_gate,
  input  wire logic                              select_low,
  input  wire logic                              row_strobe_n,
  input  wire logic                              column_strobe_n,
  input  wire logic                              write_strobe_n,
  input  wire logic                              bank_select,
  input  wire logic                              bank_select_hi,
  input  wire logic [AW-1:0]                     addr,
  // write data path
  input  wire logic [MW*8-1:0]                   data_io,
  input  wire logic [MW-1:0]                     byte_mask,
  input  wire logic                              data_valid,
  // status
  output logic [NB*3-1:0]                        bank_states,
  output logic [1:0]                             dev_mode,
  output logic                                   refresh_busy,
  output logic                                   mode_busy,
  output logic [AW-1:0]                          refresh_row,
  output logic [AW-1:0]                          std_mode_reg,
  output logic [AW-1:0]                          ext_mode_reg,
  output logic [MW*8-1:0]                        write_word,
  output logic [MW-1:0]                          write_lanes,
  output logic                                   write_strobe,
  output logic [lpddr_cmd_pkg::COL_W-1:0]        burst_col,
  output logic                                   protocol_error
);
  localparam int TW = lpddr_cmd_pkg::TMR_W;
  localparam logic [TW-1:0] T_REF  = TW'(lpddr_cmd_pkg::REFRESH_CYC);
  localparam logic [TW-1:0] T_MODE = TW'(lpddr_cmd_pkg::MODE_CYC);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: pins arrive from outside the clock domain

  logic [AW+MW*9+8-1:0] pin_s1_q;
  logic [AW+MW*9+8-1:0] pin_s2_q;

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end
    else
    begin
      pin_s1_q <= {clock_gate, select_low, row_strobe_n, column_strobe_n,
                   write_strobe_n, bank_select_hi, bank_select, data_valid,
                   addr, data_io, byte_mask};
      pin_s2_q <= pin_s1_q;
    end
  end

  logic          cke_s;
  logic [3:0]    enc_s;
  logic [1:0]    ba_s;
  logic          dv_s;
  logic [AW-1:0] addr_s;
  logic [MW*8-1:0] data_s;
  logic [MW-1:0] mask_s;

  assign {cke_s, enc_s, ba_s, dv_s, addr_s, data_s, mask_s} =
         {pin_s2_q[AW+MW*9+7], pin_s2_q[AW+MW*9+6:AW+MW*9+3],
          pin_s2_q[AW+MW*9+2:AW+MW*9+1], pin_s2_q[AW+MW*9],
          pin_s2_q[AW+MW*9-1:0]};

  //////////////////////////////////////////////////////////////////////////////
  // command decode

  // maps pin encoding and clock gate to a command
  function automatic lpddr_cmd_pkg::cmd_t decode(input logic [3:0] e, input logic cke);
    lpddr_cmd_pkg::cmd_t c;
    c = lpddr_cmd_pkg::CMD_BAD;
    if (e[3])
      c = lpddr_cmd_pkg::CMD_DESEL;                          // [RULE17] [RULE24]
    else
      case (e)
        lpddr_cmd_pkg::ENC_IDLE:  c = lpddr_cmd_pkg::CMD_IDLE; // [RULE17]
        lpddr_cmd_pkg::ENC_ACT:   c = cke ? lpddr_cmd_pkg::CMD_ACT : lpddr_cmd_pkg::CMD_BAD;
        lpddr_cmd_pkg::ENC_READ:  c = cke ? lpddr_cmd_pkg::CMD_READ : lpddr_cmd_pkg::CMD_BAD;
        lpddr_cmd_pkg::ENC_WRITE: c = cke ? lpddr_cmd_pkg::CMD_WRITE : lpddr_cmd_pkg::CMD_BAD;
        lpddr_cmd_pkg::ENC_TERM:  c = cke ? lpddr_cmd_pkg::CMD_TERM
                                          : lpddr_cmd_pkg::CMD_SLEEP;   // [RULE16]
        lpddr_cmd_pkg::ENC_PRE:   c = cke ? lpddr_cmd_pkg::CMD_PRE : lpddr_cmd_pkg::CMD_BAD;
        lpddr_cmd_pkg::ENC_REF:   c = cke ? lpddr_cmd_pkg::CMD_REF
                                          : lpddr_cmd_pkg::CMD_SELF_REF; // [RULE14]
        lpddr_cmd_pkg::ENC_MODE:  c = cke ? lpddr_cmd_pkg::CMD_MODE : lpddr_cmd_pkg::CMD_BAD;
        default:                  c = lpddr_cmd_pkg::CMD_BAD;
      endcase
    return c;
  endfunction

  lpddr_cmd_pkg::cmd_t cmd;
  logic                cke_prev_q;
  logic                run;

  always_ff @(posedge clock)
  begin
    if (!nrst)
      cke_prev_q <= 1'b0;
    else
      cke_prev_q <= cke_s;
  end

  //////////////////////////////////////////////////////////////////////////////
  // device mode

  lpddr_cmd_pkg::dev_state_t dev_q;
  logic [TW-1:0]             ref_tmr_q;
  logic [TW-1:0]             mode_tmr_q;

  assign cmd = decode(enc_s, cke_s);
  // commands execute only in normal mode, clock gate high on two edges [RULE21]
  assign run = (dev_q == lpddr_cmd_pkg::DEV_NORMAL) && cke_s && cke_prev_q;

  logic all_idle;
  logic any_read_plain;
  lpddr_cmd_pkg::bank_state_t bst [NB];
  logic [NB-1:0] ap_pend;

  always_comb
  begin
    all_idle       = (ref_tmr_q == '0) && (mode_tmr_q == '0);
    any_read_plain = 1'b0;
    for (int i = 0; i < NB; i++)
    begin
      if (bst[i] != lpddr_cmd_pkg::BANK_IDLE)
        all_idle = 1'b0;
      if (bst[i] == lpddr_cmd_pkg::BANK_READ && !ap_pend[i])
        any_read_plain = 1'b1;
    end
  end

  // self refresh holds while clock gate stays low; deep sleep only leaves on reset
  always_ff @(posedge clock)
  begin
    if (!nrst)
      dev_q <= lpddr_cmd_pkg::DEV_NORMAL;
    else
      case (dev_q)
        lpddr_cmd_pkg::DEV_NORMAL:
        begin
          if (cke_prev_q && cmd == lpddr_cmd_pkg::CMD_SELF_REF && all_idle)
            dev_q <= lpddr_cmd_pkg::DEV_SELF_REFRESH;         // [RULE14]
          else if (cke_prev_q && cmd == lpddr_cmd_pkg::CMD_SLEEP && all_idle)
            dev_q <= lpddr_cmd_pkg::DEV_DEEP_SLEEP;           // [RULE16]
        end
        lpddr_cmd_pkg::DEV_SELF_REFRESH:
          if (cke_s)
            dev_q <= lpddr_cmd_pkg::DEV_NORMAL;               // all else ignored [RULE14]
        lpddr_cmd_pkg::DEV_DEEP_SLEEP:
          dev_q <= dev_q;
        default: dev_q <= lpddr_cmd_pkg::DEV_NORMAL;
      endcase
  end

  // deep sleep holds every bank state at idle; the open row latches keep their value
  logic wipe;
  assign wipe = (dev_q == lpddr_cmd_pkg::DEV_DEEP_SLEEP);

  //////////////////////////////////////////////////////////////////////////////
  // legality and per-bank requests

  logic [1:0]    tgt;
  logic [NB-1:0] sel;
  logic [NB-1:0] legal_b;
  logic          legal;

  assign tgt = ba_s;

  always_comb
  begin
    legal = 1'b1;
    for (int i = 0; i < NB; i++)
    begin
      sel[i]     = (tgt == 2'(i));
      legal_b[i] = 1'b1;
    end
    if (run)
      case (cmd)
        lpddr_cmd_pkg::CMD_ACT:                                // [RULE18]
          legal = bst[tgt] == lpddr_cmd_pkg::BANK_IDLE;
        lpddr_cmd_pkg::CMD_READ, lpddr_cmd_pkg::CMD_WRITE:     // [RULE19] [RULE20]
          legal = (bst[tgt] == lpddr_cmd_pkg::BANK_ACTIVE)
               || ((bst[tgt] == lpddr_cmd_pkg::BANK_READ
                 || bst[tgt] == lpddr_cmd_pkg::BANK_WRITE) && !ap_pend[tgt]);
        lpddr_cmd_pkg::CMD_PRE:                                // [RULE10]
        begin
          for (int i = 0; i < NB; i++)
            legal_b[i] = (bst[i] != lpddr_cmd_pkg::BANK_ACTIVATING);
          legal = addr_s[lpddr_cmd_pkg::AP_BIT] ? (&legal_b) : legal_b[tgt];
        end
        lpddr_cmd_pkg::CMD_TERM:  legal = any_read_plain;      // [RULE19]
        lpddr_cmd_pkg::CMD_REF, lpddr_cmd_pkg::CMD_MODE:
          legal = all_idle;                                    // [RULE18]
        lpddr_cmd_pkg::CMD_BAD, lpddr_cmd_pkg::CMD_SELF_REF, lpddr_cmd_pkg::CMD_SLEEP:
          legal = 1'b0;
        default: legal = 1'b1;                                 // [RULE1] [RULE24]
      endcase
  end

  logic go;
  assign go = run && legal;

  //////////////////////////////////////////////////////////////////////////////
  // bank array

  // most recent plain read, which terminate cuts regardless of bank
  logic [1:0] last_rd_q;

  genvar g;
  generate
    for (g = 0; g < NB; g++)
    begin : g_bank
      bank_tracker u_bank
      (
        .clock      (clock),
        .nrst       (nrst),
        .do_act     (go && cmd == lpddr_cmd_pkg::CMD_ACT && sel[g]),
        .do_read    (go && cmd == lpddr_cmd_pkg::CMD_READ && sel[g]),
        .do_write   (go && cmd == lpddr_cmd_pkg::CMD_WRITE && sel[g]),
        .do_pre     (go && cmd == lpddr_cmd_pkg::CMD_PRE
                     && (addr_s[lpddr_cmd_pkg::AP_BIT] || sel[g])),  // [RULE10]
        .do_term    (go && cmd == lpddr_cmd_pkg::CMD_TERM && 2'(g) == last_rd_q),
        .auto_pre   (addr_s[lpddr_cmd_pkg::AP_BIT]),
        .row        (addr_s),
        .wipe       (wipe),
        .state      (bst[g]),
        .ap_pending (ap_pend[g]),
        .open_row   ()
      );
    end
  endgenerate

  always_ff @(posedge clock)
  begin
    if (!nrst)
      last_rd_q <= '0;
    else if (go && cmd == lpddr_cmd_pkg::CMD_READ && !addr_s[lpddr_cmd_pkg::AP_BIT])
      last_rd_q <= tgt;                                        // [RULE12]
  end

  //////////////////////////////////////////////////////////////////////////////
  // refresh, mode registers and timers

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      ref_tmr_q   <= '0;
      refresh_row <= '0;
    end
    else if (go && cmd == lpddr_cmd_pkg::CMD_REF)
    begin
      ref_tmr_q   <= T_REF;                                    // [RULE13]
      refresh_row <= refresh_row + 1'b1;                       // address pins ignored [RULE13]
    end
    else if (ref_tmr_q != '0)
      ref_tmr_q <= ref_tmr_q - 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      mode_tmr_q   <= '0;
      std_mode_reg <= '0;
      ext_mode_reg <= '0;
    end
    else if (go && cmd == lpddr_cmd_pkg::CMD_MODE)
    begin
      mode_tmr_q <= T_MODE;
      // status register target is read-only, so a load there stores nothing
      if (tgt == lpddr_cmd_pkg::MR_STD)
        std_mode_reg <= addr_s;                                // [RULE23]
      else if (tgt == lpddr_cmd_pkg::MR_EXT)
        ext_mode_reg <= addr_s;                                // [RULE23]
    end
    else if (mode_tmr_q != '0)
      mode_tmr_q <= mode_tmr_q - 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // write data masking: a lane is written only with its mask low

  logic any_write;

  always_comb
  begin
    any_write = 1'b0;
    for (int i = 0; i < NB; i++)
      if (bst[i] == lpddr_cmd_pkg::BANK_WRITE)
        any_write = 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      write_word   <= '0;
      write_lanes  <= '0;
      write_strobe <= 1'b0;
      burst_col    <= '0;
    end
    else
    begin
      write_strobe <= any_write && dv_s;
      write_lanes  <= (any_write && dv_s) ? ~mask_s : '0;      // [RULE8]
      write_word   <= data_s;
      if (go && (cmd == lpddr_cmd_pkg::CMD_READ || cmd == lpddr_cmd_pkg::CMD_WRITE))
        burst_col <= addr_s[lpddr_cmd_pkg::COL_W-1:0];         // [RULE5]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status outputs, all registered

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      bank_states    <= '0;
      dev_mode       <= '0;
      refresh_busy   <= 1'b0;
      mode_busy      <= 1'b0;
      protocol_error <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < NB; i++)
        bank_states[i*3 +: 3] <= bst[i];
      dev_mode       <= dev_q;
      refresh_busy   <= ref_tmr_q != '0;
      mode_busy      <= mode_tmr_q != '0;
      protocol_error <= run && !legal;                         // [RULE26]
    end
  end

endmodule
`default_nettype wire

// ==== test/lpddr_chk.sv ====
// concurrent checks on the command decoder status ports
`timescale 1ns/1ps
`default_nettype none
module lpddr_chk
#(
  parameter int NB = 4,
  parameter int AW = 13
)
(
  // clock and reset
  input wire logic            clock,
  input wire logic            nrst,
  // status
  input wire logic [NB*3-1:0] bank_states,
  input wire logic [1:0]      dev_mode,
  input wire logic            refresh_busy,
  input wire logic            mode_busy,
  input wire logic [AW-1:0]   refresh_row
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // bank zero stands for all banks, they share one tracker design
  logic [2:0] b0;
  assign b0 = bank_states[2:0];
  ////////////////////////////////////////////////////////////////////////////
  mode_range_a: assert property (dev_mode != 2'h3) else $error("bad mode");
  sleep_hold_a: assert property (dev_mode == 2'h2 |=> dev_mode == 2'h2)
    else $error("left deep sleep");
  sleep_idle_a: assert property ($rose(dev_mode == 2'h2) |-> $past(bank_states) == '0)
    else $error("sleep with open bank");
  act_short_a: assert property (b0 == 3'h1 |=> b0 == 3'h2) else $error("activate len");
  pre_short_a: assert property (b0 == 3'h5 |=> b0 == 3'h0) else $error("precharge len");
  ref_len_a: assert property ($rose(refresh_busy) |=> refresh_busy ##1 !refresh_busy)
    else $error("refresh len");
  mode_len_a: assert property ($rose(mode_busy) |=> !mode_busy) else $error("mode len");
  ref_count_a: assert property ($changed(refresh_row) && dev_mode == 2'h0
    |-> refresh_row == AW'($past(refresh_row) + 1)) else $error("refresh step");
  busy_idle_a: assert property (refresh_busy || mode_busy |-> bank_states == '0)
    else $error("busy with open bank");
endmodule
bind lpddr_command_bank_state lpddr_chk #(.NB(NB), .AW(AW)) chk (.clock(clock), .nrst(nrst),
  .bank_states(bank_states), .dev_mode(dev_mode), .refresh_busy(refresh_busy),
  .mode_busy(mode_busy), .refresh_row(refresh_row));
`default_nettype wire

// ==== test/host_model.sv ====
// memory controller model driving the command and write data pins
`timescale 1ns/1ps
`default_nettype none
module host_model
(
  // clock
  input  wire logic          clock,
  // command pins
  output var logic           clock_gate,
  output var logic           select_low,
  output var logic           row_strobe_n,
  output var logic           column_strobe_n,
  output var logic           write_strobe_n,
  output var logic           bank_select,
  output var logic           bank_select_hi,
  output var logic [12:0]    addr,
  // write data
  output var logic [15:0]    data_io,
  output var logic [1:0]     byte_mask,
  output var logic           data_valid
);
  // one command per edge, set at falling edge
  task automatic cmd(input logic [3:0] e, input logic [1:0] b, input logic [12:0] a,
                     input logic cg);
    {select_low, row_strobe_n, column_strobe_n, write_strobe_n} = e;
    {bank_select_hi, bank_select} = b;
    addr = a;
    clock_gate = cg;
    @(negedge clock);
  endtask
  // idle between commands; released lines flip so stale values never look valid
  task automatic gap(input int n, input logic cg = 1'b1);
    {select_low, row_strobe_n, column_strobe_n, write_strobe_n} = lpddr_cmd_pkg::ENC_IDLE;
    clock_gate = cg;
    addr = ~addr;
    data_io = ~data_io;
    data_valid = 1'b0;
    repeat (n) @(negedge clock);
  endtask
  // write beat, mask high drops a byte
  task automatic beat(input logic [15:0] d, input logic [1:0] m);
    data_io = d;
    byte_mask = m;
    data_valid = 1'b1;
  endtask
  initial
  begin
    {addr, data_io, byte_mask, bank_select_hi, bank_select} = '0;
    gap(0);
  end
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// self-checking bench for the command decoder and bank tracker
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  wire logic   clock_gate, select_low, row_strobe_n, column_strobe_n, write_strobe_n;
  wire logic   bank_select, bank_select_hi, data_valid, write_strobe, protocol_error;
  wire logic   [12:0] addr, refresh_row, std_mode_reg, ext_mode_reg;
  wire logic   [15:0] data_io, write_word;
  wire logic   [1:0] byte_mask, write_lanes, dev_mode;
  wire logic   [11:0] bank_states;
  wire logic   [8:0] burst_col;
  int          n_errors = 0;
  int          tests_run = 0;
  logic        err_seen = 1'b0;
  logic [15:0] got_word;
  logic [1:0]  got_lanes;
  always #20 clock = ~clock;
  host_model host (.clock, .clock_gate, .select_low, .row_strobe_n, .column_strobe_n,
    .write_strobe_n, .bank_select, .bank_select_hi, .addr, .data_io, .byte_mask, .data_valid);
  lpddr_command_bank_state dut (.clock, .nrst, .clock_gate, .select_low, .row_strobe_n,
    .column_strobe_n, .write_strobe_n, .bank_select, .bank_select_hi, .addr, .data_io,
    .byte_mask, .data_valid, .bank_states, .dev_mode, .refresh_busy(), .mode_busy(),
    .refresh_row, .std_mode_reg, .ext_mode_reg, .write_word, .write_lanes, .write_strobe,
    .burst_col, .protocol_error);
  // latch pulses for later checks
  always @(posedge clock)
  begin
    if (protocol_error === 1'b1) err_seen <= 1'b1;
    if (write_strobe === 1'b1) {got_word, got_lanes} <= {write_word, write_lanes};
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  function automatic logic [2:0] bs(input int i);
    return bank_states[i*3 +: 3];
  endfunction
  // one command then enough idle edges for pipeline and timers
  task automatic op(input logic [3:0] e, input logic [1:0] b, input logic [12:0] a);
    host.cmd(e, b, a, 1'b1);
    host.gap(8);
  endtask
  task automatic reset;
    nrst = 1'b0;
    host.gap(5);
    nrst = 1'b1;
    host.gap(2);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_ref;
    op(lpddr_cmd_pkg::ENC_REF, 2'h0, 13'h1fff);
    check(refresh_row, 16'h0001, "refresh row");
    op(lpddr_cmd_pkg::ENC_REF, 2'h0, 13'h0000);
    check(refresh_row, 16'h0002, "refresh row");
    op(lpddr_cmd_pkg::ENC_MODE, 2'h0, 13'h0033);
    op(lpddr_cmd_pkg::ENC_MODE, 2'h2, 13'h0044);
    check(std_mode_reg, 16'h0033, "std mode");
    check(ext_mode_reg, 16'h0044, "ext mode");
  endtask
  task automatic t_read;
    op(lpddr_cmd_pkg::ENC_ACT, 2'h1, 13'h0123);
    check(bs(1), lpddr_cmd_pkg::BANK_ACTIVE, "open");
    op(lpddr_cmd_pkg::ENC_READ, 2'h1, 13'h0005);
    check(bs(1), lpddr_cmd_pkg::BANK_ACTIVE, "plain read");
    check(burst_col, 16'h0005, "column");
    op(lpddr_cmd_pkg::ENC_READ, 2'h1, 13'h0407);
    check(bs(1), lpddr_cmd_pkg::BANK_IDLE, "ap read");
    check(burst_col, 16'h0007, "column");
  endtask
  task automatic t_write;
    op(lpddr_cmd_pkg::ENC_ACT, 2'h0, 13'h0011);
    host.beat(16'ha5c3, 2'h2);
    host.cmd(lpddr_cmd_pkg::ENC_WRITE, 2'h0, 13'h0409, 1'b1);
    repeat (2) @(negedge clock);
    host.gap(8);
    check(got_lanes, 16'h0001, "lanes");
    check(got_word[7:0], 16'h00c3, "low byte");
    check(bs(0), lpddr_cmd_pkg::BANK_IDLE, "ap write");
  endtask
  task automatic t_pre;
    op(lpddr_cmd_pkg::ENC_ACT, 2'h2, 13'h0002);
    op(lpddr_cmd_pkg::ENC_ACT, 2'h3, 13'h0003);
    op(lpddr_cmd_pkg::ENC_PRE, 2'h2, 13'h0000);
    check(bs(2), lpddr_cmd_pkg::BANK_IDLE, "one bank");
    check(bs(3), lpddr_cmd_pkg::BANK_ACTIVE, "other bank");
    op(lpddr_cmd_pkg::ENC_PRE, 2'h0, 13'h0400);
    check(bs(3), lpddr_cmd_pkg::BANK_IDLE, "all banks");
  endtask
  task automatic t_term;
    op(lpddr_cmd_pkg::ENC_ACT, 2'h0, 13'h0020);
    err_seen = 1'b0;
    host.cmd(lpddr_cmd_pkg::ENC_READ, 2'h0, 13'h0003, 1'b1);
    host.cmd(lpddr_cmd_pkg::ENC_TERM, 2'h0, 13'h0000, 1'b1);
    host.gap(8);
    check(bs(0), lpddr_cmd_pkg::BANK_ACTIVE, "cut read");
    check(err_seen, 16'h0000, "term error");
    op(lpddr_cmd_pkg::ENC_PRE, 2'h0, 13'h0000);
  endtask
  task automatic t_bad;
    err_seen = 1'b0;
    op(lpddr_cmd_pkg::ENC_READ, 2'h3, 13'h0000);
    check(err_seen, 16'h0001, "illegal");
    check(bs(3), lpddr_cmd_pkg::BANK_IDLE, "illegal");
    err_seen = 1'b0;
    op(4'hd, 2'h3, 13'h0000);
    check(err_seen, 16'h0000, "deselect");
    check(bs(3), lpddr_cmd_pkg::BANK_IDLE, "deselect");
  endtask
  task automatic t_power;
    host.cmd(lpddr_cmd_pkg::ENC_REF, 2'h0, 13'h0000, 1'b0);
    host.gap(8, 1'b0);
    check(dev_mode, 16'h0001, "self refresh");
    host.cmd(lpddr_cmd_pkg::ENC_ACT, 2'h1, 13'h0000, 1'b0);
    host.gap(8, 1'b0);
    check(bs(1), lpddr_cmd_pkg::BANK_IDLE, "ignored");
    reset;
    host.cmd(lpddr_cmd_pkg::ENC_TERM, 2'h0, 13'h0000, 1'b0);
    host.gap(8);
    check(dev_mode, 16'h0002, "deep sleep");
    op(lpddr_cmd_pkg::ENC_ACT, 2'h1, 13'h0000);
    check(bs(1), lpddr_cmd_pkg::BANK_IDLE, "asleep");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    reset;
    t_ref;
    t_read;
    t_write;
    t_pre;
    t_term;
    t_bad;
    t_power;
    end_of_test;
  end
  // run needs about 220 cycles, so 5000 means a hang
  initial
  begin
    #200000;
    n_errors++;
    end_of_test;
  end
endmodule
`default_nettype wire
